// [core/fdc_field_link.sv]
// Field clock domain: turns every recovered field clock into a toggle for the system domain.
`timescale 1ns/1ps
module fdc_field_link (
    input wire logic i_clk_field,
    input wire logic i_resetn,
    output logic o_tick_tgl
);
    logic rst_meta_reg;
    logic rst_sync_reg;

    // The field clock stops during gaps, so the reset release is synchronised here
    // and the toggle simply resumes when the carrier comes back.
    always_ff @(posedge i_clk_field) begin
        rst_meta_reg <= i_resetn;
        rst_sync_reg <= rst_meta_reg;
    end

    always_ff @(posedge i_clk_field) begin
        if (!rst_sync_reg) begin
            o_tick_tgl <= 1'b0;
        end else begin
            o_tick_tgl <= ~o_tick_tgl;
        end
    end
endmodule : fdc_field_link

// [core/fdc_gap_decoder.sv]
// Downlink gap decoder and programming sequencer of a passive read/write transponder.
`timescale 1ns/1ps
// Overview of operation
// - A first gap while idle switches immediately into receive mode.
// - Frame is two opcode bits, optional 33 data bits, optional 3 or 5 address bits.
// - Coil damping stays on throughout receive mode.
// - Start gap accepted only after initialisation and outside receive mode.
// - Field clocks between gaps: 16 to 32 is zero, 48 to 64 is one.
// - More than 64 clocks between gaps ends receive mode and the frame.
// - Programming starts only for a write with exactly the right bit count.
// - First two received bits are the opcode and choose the layout.
// - Opcode 11 write: lock bit, 32 data bits, five-bit address, 40 bits.
// - Opcode 11 with five-bit address only is a 7-bit read, never programs.
// - Opcode 10 write: lock bit, 32 data bits, three-bit address, 38 bits.
// - Opcode 00 resets the device; opcode 01 is reserved for production test.
// - Damping is off for the whole erase and programming cycle.
// - Erase plus program takes about 18 ms before the verify reply.
// - Failed verify stays silent until a new start gap.
// - Locked target block skips programming and transmits that block unchanged.
// - A count up to 64 outside both bit windows is a bit error.
// - Writes other than exactly 38 or 40 bits are frame errors.
// - Read opcode with other than seven bits is a frame error.
// - Any receive error resumes cyclic transmission from the first user block.
// - A valid single-block read transmits the addressed block continuously.
module fdc_gap_decoder #(
    parameter int unsigned P_PROG_CLKS = fdc_pkg::PROG_CLKS,
    parameter int unsigned P_INIT_DELAY_CLKS = fdc_pkg::INIT_DELAY_CLKS
) (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic i_clk_field,
    input wire logic i_field_gap,
    input wire logic i_startup_delay,
    input wire logic i_ee_lock,
    input wire logic [fdc_pkg::BLK_W-1:0] i_ee_rdata,
    output logic o_downlink,
    output logic o_damp_en,
    output logic o_mod_en,
    output logic o_tx_single,
    output logic [fdc_pkg::ADDR_W-1:0] o_tx_block,
    output logic [fdc_pkg::ADDR_W-1:0] o_ee_addr,
    output logic [fdc_pkg::BLK_W-1:0] o_ee_wdata,
    output logic o_ee_prog,
    output logic o_bit_err,
    output logic o_frame_err,
    output logic o_int_reset
);
    import fdc_pkg::*;

    fdc_state_t state_reg;
    fdc_state_t state_next;

    logic tick_tgl;
    logic tgl_sync;
    logic tgl_d_reg;
    logic gap_sync;
    logic gap_d_reg;
    logic tick;
    logic gap_rise;

    logic [6:0] ivl_reg;
    logic [6:0] ivl_next;
    logic [13:0] init_reg;
    logic [13:0] init_next;
    logic [19:0] prog_reg;
    logic [19:0] prog_next;
    logic [5:0] nbits_reg;
    logic [5:0] nbits_next;
    logic [1:0] op_reg;
    logic [1:0] op_next;
    logic [39:0] shift_reg;
    logic [39:0] shift_next;
    logic [4:0] addr_reg;
    logic [4:0] addr_next;
    logic [32:0] wdata_reg;
    logic [32:0] wdata_next;
    logic [4:0] tx_block_reg;
    logic [4:0] tx_block_next;
    logic tx_single_reg;
    logic tx_single_next;
    logic bit_err_next;
    logic frame_err_next;
    logic int_reset_next;
    logic bit_err_reg;
    logic frame_err_reg;
    logic int_reset_reg;

    // Field clocks are carried across as a toggle; the system clock is several
    // times faster, so every toggle is seen as one tick.
    fdc_field_link u_field_link (
        .i_clk_field(i_clk_field),
        .i_resetn(i_resetn),
        .o_tick_tgl(tick_tgl)
    );

    fdc_sync u_sync_tick (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_async(tick_tgl),
        .o_sync(tgl_sync)
    );

    fdc_sync u_sync_gap (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_async(i_field_gap),
        .o_sync(gap_sync)
    );

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            tgl_d_reg <= 1'b0;
            gap_d_reg <= 1'b0;
        end else if (i_ce) begin
            tgl_d_reg <= tgl_sync;
            gap_d_reg <= gap_sync;
        end
    end

    assign tick = tgl_sync ^ tgl_d_reg;
    assign gap_rise = gap_sync & ~gap_d_reg;

    // Bit windows and frame classification.
    wire is_zero = (ivl_reg >= ZERO_MIN) && (ivl_reg <= ZERO_MAX);
    wire is_one = (ivl_reg >= ONE_MIN) && (ivl_reg <= ONE_MAX);
    wire bit_ok = is_zero | is_one;
    wire overlong = (ivl_reg > ONE_MAX);
    wire frm_wr5 = (op_reg == OP_ADDR5) && (nbits_reg == BITS_WR5);
    wire frm_rd = (op_reg == OP_ADDR5) && (nbits_reg == BITS_RD);
    wire frm_wr3 = (op_reg == OP_ADDR3) && (nbits_reg == BITS_WR3);
    wire frm_rst = (op_reg == OP_RESET) && (nbits_reg >= BITS_OP);
    wire [13:0] init_target = INIT_CFG_CLKS + (i_startup_delay ? 14'(P_INIT_DELAY_CLKS) : 14'h0000);
    wire init_done = (init_reg >= init_target);
    wire prog_done = (prog_reg >= 20'(P_PROG_CLKS - 1));
    wire verify_ok = (i_ee_rdata == wdata_reg);

    // Interval counter runs only while the field is on and holds at its ceiling.
    always_comb begin
        ivl_next = ivl_reg;
        if (gap_rise) begin
            ivl_next = 7'h00;
        end else if (tick && !gap_sync && ivl_reg < IVL_SAT) begin
            ivl_next = ivl_reg + 7'h01;
        end
    end

    always_comb begin
        state_next = state_reg;
        init_next = init_reg;
        prog_next = prog_reg;
        nbits_next = nbits_reg;
        op_next = op_reg;
        shift_next = shift_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        tx_block_next = tx_block_reg;
        tx_single_next = tx_single_reg;
        bit_err_next = 1'b0;
        frame_err_next = 1'b0;
        int_reset_next = 1'b0;
        case (state_reg)
            FDC_ST_INIT: begin
                // A gap during start-up restarts the whole sequence.
                if (gap_rise) begin
                    init_next = 14'h0000;
                end else if (init_done) begin
                    state_next = FDC_ST_UPLINK;
                    tx_block_next = FIRST_USER_BLOCK;
                    tx_single_next = 1'b0;
                end else if (tick) begin
                    init_next = init_reg + 14'h0001;
                end
            end
            FDC_ST_UPLINK, FDC_ST_SILENT: begin
                if (gap_rise) begin
                    state_next = FDC_ST_DOWNLINK;
                    nbits_next = 6'h00;
                    op_next = OP_RESET;
                    shift_next = SHIFT_RESET;
                end
            end
            FDC_ST_DOWNLINK: begin
                if (gap_rise) begin
                    if (bit_ok) begin
                        shift_next = {shift_reg[38:0], is_one};
                        if (nbits_reg != BITS_MAX) begin
                            nbits_next = nbits_reg + 6'h01;
                        end
                        if (nbits_reg == 6'h01) begin
                            op_next = {shift_reg[0], is_one};
                        end
                    end else begin
                        bit_err_next = 1'b1;
                        state_next = FDC_ST_UPLINK;
                        tx_block_next = FIRST_USER_BLOCK;
                        tx_single_next = 1'b0;
                    end
                end else if (overlong) begin
                    // The reader has stopped gapping: the frame is complete.
                    if (frm_wr5) begin
                        state_next = FDC_ST_LOCKCHK;
                        wdata_next = shift_reg[37:5];
                        addr_next = shift_reg[4:0];
                    end else if (frm_wr3) begin
                        state_next = FDC_ST_LOCKCHK;
                        wdata_next = shift_reg[35:3];
                        addr_next = {2'b00, shift_reg[2:0]};
                    end else if (frm_rd) begin
                        state_next = FDC_ST_UPLINK;
                        tx_block_next = shift_reg[4:0];
                        tx_single_next = 1'b1;
                    end else if (frm_rst) begin
                        state_next = FDC_ST_INIT;
                        int_reset_next = 1'b1;
                        init_next = 14'h0000;
                    end else begin
                        // Reserved test opcode and wrong lengths land here.
                        frame_err_next = 1'b1;
                        state_next = FDC_ST_UPLINK;
                        tx_block_next = FIRST_USER_BLOCK;
                        tx_single_next = 1'b0;
                    end
                end
            end
            FDC_ST_LOCKCHK: begin
                tx_block_next = addr_reg;
                tx_single_next = 1'b1;
                if (i_ee_lock) begin
                    state_next = FDC_ST_UPLINK;
                end else begin
                    state_next = FDC_ST_PROG;
                    prog_next = 20'h00000;
                end
            end
            FDC_ST_PROG: begin
                if (prog_done) begin
                    state_next = FDC_ST_VERIFY;
                end else begin
                    prog_next = prog_reg + 20'h00001;
                end
            end
            FDC_ST_VERIFY: begin
                if (verify_ok) begin
                    state_next = FDC_ST_UPLINK;
                end else begin
                    state_next = FDC_ST_SILENT;
                end
            end
            default: begin
                state_next = FDC_ST_INIT;
                init_next = 14'h0000;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            state_reg <= FDC_ST_INIT;
            ivl_reg <= IVL_SAT;
            init_reg <= 14'h0000;
            prog_reg <= 20'h00000;
        end else if (i_ce) begin
            state_reg <= state_next;
            ivl_reg <= ivl_next;
            init_reg <= init_next;
            prog_reg <= prog_next;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            nbits_reg <= 6'h00;
            op_reg <= OP_RESET;
            shift_reg <= SHIFT_RESET;
            addr_reg <= ADDR_RESET;
            wdata_reg <= BLK_RESET;
        end else if (i_ce) begin
            nbits_reg <= nbits_next;
            op_reg <= op_next;
            shift_reg <= shift_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            tx_block_reg <= FIRST_USER_BLOCK;
            tx_single_reg <= 1'b0;
            bit_err_reg <= 1'b0;
            frame_err_reg <= 1'b0;
            int_reset_reg <= 1'b0;
        end else if (i_ce) begin
            tx_block_reg <= tx_block_next;
            tx_single_reg <= tx_single_next;
            bit_err_reg <= bit_err_next;
            frame_err_reg <= frame_err_next;
            int_reset_reg <= int_reset_next;
        end
    end

    // Damping is a pure function of state so it can never linger into programming.
    assign o_downlink = (state_reg == FDC_ST_DOWNLINK);
    assign o_damp_en = (state_reg == FDC_ST_DOWNLINK);
    assign o_mod_en = (state_reg == FDC_ST_UPLINK);
    assign o_ee_prog = (state_reg == FDC_ST_PROG);
    assign o_tx_block = tx_block_reg;
    assign o_tx_single = tx_single_reg;
    assign o_ee_addr = addr_reg;
    assign o_ee_wdata = wdata_reg;
    assign o_bit_err = bit_err_reg;
    assign o_frame_err = frame_err_reg;
    assign o_int_reset = int_reset_reg;
endmodule : fdc_gap_decoder

// [core/fdc_pkg.sv]
// Shared constants and types for the downlink gap decoder.
package fdc_pkg;
    localparam int unsigned CLK_FREQ_HZ = 50_000_000;
    localparam int unsigned PROG_TIME_MS = 18;
    localparam int unsigned PROG_CLKS = PROG_TIME_MS * (CLK_FREQ_HZ / 1000);
    localparam int unsigned INIT_DELAY_CLKS = 8192;
    localparam logic [13:0] INIT_CFG_CLKS = 14'h0072;
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned BLK_W = 33;
    localparam int unsigned SHIFT_W = 40;
    localparam logic [6:0] ZERO_MIN = 7'h10;
    localparam logic [6:0] ZERO_MAX = 7'h20;
    localparam logic [6:0] ONE_MIN = 7'h30;
    localparam logic [6:0] ONE_MAX = 7'h40;
    localparam logic [6:0] IVL_SAT = 7'h41;
    localparam logic [5:0] BITS_WR5 = 6'h28;
    localparam logic [5:0] BITS_WR3 = 6'h26;
    localparam logic [5:0] BITS_RD = 6'h07;
    localparam logic [5:0] BITS_OP = 6'h02;
    localparam logic [5:0] BITS_MAX = 6'h3F;
    localparam logic [1:0] OP_RESET = 2'h0;
    localparam logic [1:0] OP_TEST = 2'h1;
    localparam logic [1:0] OP_ADDR3 = 2'h2;
    localparam logic [1:0] OP_ADDR5 = 2'h3;
    localparam logic [4:0] FIRST_USER_BLOCK = 5'h01;
    localparam logic [4:0] ADDR_RESET = 5'h00;
    localparam logic [32:0] BLK_RESET = 33'h000000000;
    localparam logic [39:0] SHIFT_RESET = 40'h0000000000;

    typedef enum logic [2:0] {
        FDC_ST_INIT = 3'b000,
        FDC_ST_UPLINK = 3'b001,
        FDC_ST_DOWNLINK = 3'b010,
        FDC_ST_LOCKCHK = 3'b011,
        FDC_ST_PROG = 3'b100,
        FDC_ST_VERIFY = 3'b101,
        FDC_ST_SILENT = 3'b110
    } fdc_state_t;
endpackage : fdc_pkg

// [core/fdc_sync.sv]
// Two flip-flop level synchroniser into the system clock domain.
`timescale 1ns/1ps
module fdc_sync (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic i_async,
    output logic o_sync
);
    logic meta_reg;

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            meta_reg <= 1'b0;
            o_sync <= 1'b0;
        end else if (i_ce) begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end
endmodule : fdc_sync

// [verif/fdc_gap_decoder_chk.sv]
// Port-level assertions for the downlink gap decoder.
`timescale 1ns/1ps
module fdc_gap_decoder_chk #(
    parameter int unsigned P_PROG_CLKS = 50,
    parameter int unsigned P_INIT_DELAY_CLKS = 20
) (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic o_downlink,
    input wire logic o_damp_en,
    input wire logic o_mod_en,
    input wire logic o_tx_single,
    input wire logic [fdc_pkg::ADDR_W-1:0] o_tx_block,
    input wire logic [fdc_pkg::ADDR_W-1:0] o_ee_addr,
    input wire logic o_ee_prog,
    input wire logic o_bit_err,
    input wire logic o_frame_err,
    input wire logic o_int_reset
);
    import fdc_pkg::*;
    int unsigned prog_cnt;
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn || !o_ee_prog) prog_cnt <= 0;
        else prog_cnt <= prog_cnt + 1;
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    property p_damp_rx; o_downlink |-> o_damp_en; endproperty
    a_damp_rx: assert property (p_damp_rx) else $error("damping off in receive");
    property p_rx_nomod; o_downlink |-> !o_mod_en; endproperty
    a_rx_nomod: assert property (p_rx_nomod) else $error("modulation in receive");
    property p_prog_damp; o_ee_prog |-> !o_damp_en && !o_downlink && !o_mod_en; endproperty
    a_prog_damp: assert property (p_prog_damp) else $error("damping during program");
    property p_prog_len; (!o_ee_prog && prog_cnt != 0) |-> prog_cnt == P_PROG_CLKS; endproperty
    a_prog_len: assert property (p_prog_len) else $error("program pulse length");
    property p_prog_start; $rose(o_ee_prog) |-> !$past(o_downlink) && $past(o_downlink, 2); endproperty
    a_prog_start: assert property (p_prog_start) else $error("program without frame");
    property p_prog_end;
        $fell(o_ee_prog) ##[1:3] $rose(o_mod_en) |-> o_tx_single && o_tx_block == o_ee_addr;
    endproperty
    a_prog_end: assert property (p_prog_end) else $error("wrong block after verify");
    property p_bit_err;
        o_bit_err |-> ##[0:2] (o_mod_en && !o_tx_single && o_tx_block == FIRST_USER_BLOCK);
    endproperty
    a_bit_err: assert property (p_bit_err) else $error("no restart after bit error");
    property p_frame_err;
        o_frame_err |-> ##[0:2] (o_mod_en && !o_tx_single && o_tx_block == FIRST_USER_BLOCK);
    endproperty
    a_frame_err: assert property (p_frame_err) else $error("no restart after frame error");
    property p_int_reset; o_int_reset |=> (!o_mod_en && !o_downlink) [*8]; endproperty
    a_int_reset: assert property (p_int_reset) else $error("no init after reset command");

    c_prog: cover property ($fell(o_ee_prog));
    c_bit: cover property (o_bit_err);
    c_frame: cover property (o_frame_err);
    c_reset: cover property (o_int_reset);
endmodule : fdc_gap_decoder_chk

bind fdc_gap_decoder fdc_gap_decoder_chk #(
    .P_PROG_CLKS(P_PROG_CLKS),
    .P_INIT_DELAY_CLKS(P_INIT_DELAY_CLKS)
) i_chk (
    .i_clk_sys, .i_resetn, .o_downlink, .o_damp_en, .o_mod_en, .o_tx_single,
    .o_tx_block, .o_ee_addr, .o_ee_prog, .o_bit_err, .o_frame_err, .o_int_reset
);

// [verif/fdc_reader_model.sv]
// Reader side model: drives the field clock and the field gaps of the downlink.
`timescale 1ns/1ps
module fdc_reader_model (
    output logic o_clk_field,
    output logic o_field_gap
);
    initial begin
        o_clk_field = 1'b0;
        o_field_gap = 1'b0;
    end

    // The field clock runs only while the field is on, so it stands still in every gap.
    task automatic ticks(input int n);
        repeat (n) begin
            #40 o_clk_field = 1'b1;
            #40 o_clk_field = 1'b0;
        end
    endtask : ticks

    // Gaps are far shorter than on air to keep the run short; the start gap stays twice as long.
    task automatic gap(input bit start);
        o_field_gap = 1'b1;
        #(start ? 480 : 240);
        o_field_gap = 1'b0;
    endtask : gap

    // Each interval closes with a gap; a long field-on phase ends the frame.
    task automatic send(input int iv[$]);
        gap(1'b1);
        foreach (iv[i]) begin
            ticks(iv[i]);
            gap(1'b0);
        end
        ticks(70);
    endtask : send
endmodule : fdc_reader_model

// [verif/tb_rfid_downlink_gap_decoder.sv]
// Self-checking bench for the downlink gap decoder with a reader model.
`timescale 1ns/1ps
module tb_rfid_downlink_gap_decoder;
    import fdc_pkg::*;
    localparam int PROG = 50;
    typedef bit fdc_bits_t[$];
    logic i_clk_sys, i_clk_field, i_field_gap, i_ee_lock, bad;
    logic i_resetn = 1'b0;
    logic ce = 1'b1;
    logic sdly = 1'b0;
    logic [BLK_W-1:0] i_ee_rdata, o_ee_wdata;
    logic o_downlink, o_damp_en, o_mod_en, o_tx_single, o_ee_prog, o_bit_err, o_frame_err, o_int_reset;
    logic [ADDR_W-1:0] o_tx_block, o_ee_addr, adr;
    logic [39:0] v;
    logic [BLK_W-1:0] mem [32];
    bit exp_lk [32];
    int n_errors = 0, checks_done = 0, cyc = 0, n_be = 0, n_fe = 0, n_ir = 0, n_pg = 0, seed, be;
    logic [1:0] ops [11] = '{2'h3, 2'h3, 2'h3, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h1, 2'h0};
    int ns [11] = '{40, 40, 40, 38, 40, 7, 20, 39, 7, 7, 2};
    int bad_iv [4] = '{8, 15, 33, 47};

    fdc_gap_decoder #(.P_PROG_CLKS(PROG), .P_INIT_DELAY_CLKS(20)) i_dut (
        .i_clk_sys, .i_resetn, .i_ce(ce), .i_clk_field, .i_field_gap, .i_startup_delay(sdly),
        .i_ee_lock, .i_ee_rdata, .o_downlink, .o_damp_en, .o_mod_en, .o_tx_single, .o_tx_block,
        .o_ee_addr, .o_ee_wdata, .o_ee_prog, .o_bit_err, .o_frame_err, .o_int_reset
    );
    fdc_reader_model i_rdr (.o_clk_field(i_clk_field), .o_field_gap(i_field_gap));

    // The memory answers at once, as the decoder samples it in the same cycle.
    assign i_ee_lock = mem[o_ee_addr][32];
    assign i_ee_rdata = mem[o_ee_addr] ^ {32'h00000000, bad};

    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end

    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        n_be <= n_be + int'(o_bit_err === 1'b1);
        n_fe <= n_fe + int'(o_frame_err === 1'b1);
        n_ir <= n_ir + int'(o_int_reset === 1'b1);
        n_pg <= n_pg + int'(o_ee_prog === 1'b1);
        if (o_ee_prog === 1'b1) mem[o_ee_addr] <= o_ee_wdata;
        if (cyc == 90000) begin
            n_errors++;
            complete_run();
        end
    end

    task automatic chk(input logic [39:0] g, input logic [39:0] e);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    function automatic fdc_bits_t bits(input logic [39:0] w, input int n);
        fdc_bits_t q;
        for (int i = 39; i > 39 - n; i--) q.push_back(w[i]);
        return q;
    endfunction : bits

    // Reference model: works out layout, address and data from the bits sent.
    task automatic run(input fdc_bits_t b, input bit vfail);
        int iv[$];
        int n, fe, ir, pg;
        logic [1:0] op;
        logic [32:0] wd;
        logic [4:0] a;
        bit wr, rd, ok;
        n = b.size();
        op = {b[0], b[1]};
        wd = '0;
        a = '0;
        foreach (b[i]) iv.push_back(b[i] ? 48 + ($random(seed) & 16) : 16 + ($random(seed) & 16));
        wr = (op == OP_ADDR5 && n == 40) || (op == OP_ADDR3 && n == 38);
        rd = op == OP_ADDR5 && n == 7;
        for (int i = 2; i < 35 && wr; i++) wd = {wd[31:0], b[i]};
        for (int i = wr ? 35 : 2; i < n && (wr || rd); i++) a = {a[3:0], b[i]};
        fe = n_fe;
        ir = n_ir;
        pg = n_pg;
        bad = vfail;
        fork
            i_rdr.send(iv);
            begin
                repeat (60) @(posedge i_clk_sys);
                chk(o_downlink & o_damp_en & ~o_mod_en, 40'h1);
            end
        join
        repeat (PROG + 40) @(posedge i_clk_sys);
        ok = !(vfail && !exp_lk[a]);
        if (op == OP_RESET) begin
            chk(40'(n_ir - ir), 40'h1);
            chk(o_mod_en, 40'h0);
            i_rdr.ticks(160);
        end else if (wr) begin
            chk(o_ee_addr, a);
            chk(o_ee_wdata, wd);
            chk(40'(n_pg - pg), exp_lk[a] ? 40'h0 : 40'(PROG));
            chk(o_mod_en, ok);
            if (ok) chk({o_tx_single, o_tx_block}, {1'b1, a});
            if (!exp_lk[a]) exp_lk[a] = wd[32];
        end else if (rd) begin
            chk({o_tx_single, o_tx_block}, {1'b1, a});
            chk(40'(n_pg - pg), 40'h0);
        end else begin
            chk(40'(n_fe - fe), 40'h1);
            chk({o_tx_single, o_tx_block}, {1'b0, FIRST_USER_BLOCK});
        end
        $display("frame of %0d bits done", n);
    endtask : run

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    initial begin
        seed = 32'h7BB8BFA6;
        bad = 1'b0;
        foreach (mem[i]) mem[i] = '0;
        adr = 5'($random(seed));
        // Reset spans two field periods so the field side sees it too.
        fork
            i_rdr.ticks(60);
            begin
                repeat (10) @(posedge i_clk_sys);
                i_resetn <= 1'b1;
            end
        join
        i_rdr.gap(1'b1);
        repeat (10) @(posedge i_clk_sys);
        chk(o_downlink, 40'h0);
        i_rdr.ticks(100);
        chk(o_mod_en, 40'h0);
        i_rdr.ticks(30);
        chk(o_mod_en, 40'h1);
        $display("init test done");
        for (int k = 0; k < 11; k++) begin
            v = {ops[k], 38'({$random(seed), $random(seed)})};
            if (k == 0) v[37] = 1'b0;
            if (k == 1 || k == 2) v[37] = 1'b1;
            if (k == 1 || k == 2) v[4:0] = adr;
            if (k == 5) v[37:33] = adr;
            run(bits(v, ns[k]), k == 4);
        end
        // With the start-up delay set, a reset command must hold off uplink for 20 more field clocks.
        @(posedge i_clk_sys);
        sdly <= 1'b1;
        i_rdr.send('{24, 24});
        i_rdr.ticks(120);
        chk(o_mod_en, 40'h0);
        i_rdr.ticks(25);
        chk(o_mod_en, 40'h1);
        @(posedge i_clk_sys);
        sdly <= 1'b0;
        $display("start-up delay test done");
        foreach (bad_iv[k]) begin
            be = n_be;
            i_rdr.send('{56, 24, bad_iv[k]});
            repeat (20) @(posedge i_clk_sys);
            chk(40'(n_be - be), 40'h1);
            chk({o_tx_single, o_tx_block}, {1'b0, FIRST_USER_BLOCK});
            $display("bit error test done");
        end
        complete_run();
    end
endmodule : tb_rfid_downlink_gap_decoder
